// ===== gcp_counter_top.v
// Overview of operation
// - each counter counts transitions of one selected source: pin, trigger, timebase or companion tc.
// - the edge select picks rising or falling transitions of a selected pin or trigger source.
// - each counter takes its gate from a pin, trigger, acquisition trigger or companion output.
// - the gate sense select inverts the gate where the application uses it.
// - tallies start from a programmable 24-bit starting value.
// - generation uses programmable 24-bit durations a/b, plus c/d in fsk, each at least two.
// - in fsk, durations a/b serve one gate state and c/d the other.
// - each reload of duration a adds the 8-bit reload step to the stored a.
// - direction control applies only to plain and stored event tallies, by software or line.
// - default is software direction counting up; software-down starts counting down.
// - up and down commands change direction while counting under software control.
// - line-driven direction uses io line 6 for counter 0 and 7 for counter 1, low means down.
// - the output toggles on each terminal count, or strobes once in strobe mode.
// - output sense normal rests low, inverted rests high.
// - commands are prepare, arm, prepare then arm, reset, count up and count down.
//
// Decided for this implementation: the APB slave port and the register offsets.
`include "gcp_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module gcp_counter_top #(
    parameter FAST_DIV = `GCP_FAST_DIV,
    parameter SLOW_DIV = `GCP_SLOW_DIV
) (
    input wire clock,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire [9:0] connectorPin,
    input wire [6:0] triggerLine,
    input wire acquisitionBeginTrigger,
    input wire acquisitionEndTrigger,
    input wire [7:0] parallelIoLine,
    output wire [1:0] counterOut,
    output wire [1:0] terminalCount,
    output wire irq
);
    // =================================================================
    // pin synchronisation
    wire [26:0] syncIn;
    wire [26:0] syncOut;
    wire [9:0] pinS;
    wire [6:0] trigS;
    wire acqBeginS;
    wire acqEndS;
    wire [7:0] pioS;

    assign syncIn = {parallelIoLine, acquisitionEndTrigger, acquisitionBeginTrigger,
                     triggerLine, connectorPin};
    assign pinS = syncOut[9:0];
    assign trigS = syncOut[16:10];
    assign acqBeginS = syncOut[17];
    assign acqEndS = syncOut[18];
    assign pioS = syncOut[26:19];

    gcp_sync #(
        .WIDTH(27)
    ) pinSync (
        .clock(clock),
        .reset(reset),
        .async(syncIn),
        .synced(syncOut)
    );

    // =================================================================
    // internal timebases, one-cycle ticks
    reg [15:0] fastDiv_q;
    reg [15:0] slowDiv_q;
    wire fastTick;
    wire slowTick;

    assign fastTick = (fastDiv_q == FAST_DIV[15:0] - 16'h0001);
    assign slowTick = (slowDiv_q == SLOW_DIV[15:0] - 16'h0001);

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            fastDiv_q <= 16'h0000;
            slowDiv_q <= 16'h0000;
        end else begin
            fastDiv_q <= fastTick ? 16'h0000 : fastDiv_q + 16'h0001;
            slowDiv_q <= slowTick ? 16'h0000 : slowDiv_q + 16'h0001;
        end
    end

    // =================================================================
    // apb decode
    wire setup;
    wire wrAcc;
    wire [1:0] tcW;
    wire [1:0] outW;
    wire [1:0] hitW;
    wire [31:0] rd0W;
    wire [31:0] rd1W;
    reg [1:0] intStat_q;
    reg [1:0] intMask_q;
    reg err_q;
    reg [31:0] rdSel;
    reg hitSel;

    assign setup = psel & ~penable;
    assign wrAcc = psel & penable & pwrite;
    assign pready = psel & penable;
    assign pslverr = psel & penable & err_q;
    assign terminalCount = tcW;
    assign counterOut = outW;
    assign irq = |(intStat_q & intMask_q);

    always @* begin
        rdSel = 32'h00000000;
        hitSel = 1'b1;
        if (paddr == `GCP_OFS_INTSTAT) begin
            rdSel = {30'h00000000, intStat_q};
        end else if (paddr == `GCP_OFS_INTMASK) begin
            rdSel = {30'h00000000, intMask_q};
        end else if (hitW[0]) begin
            rdSel = rd0W;
        end else if (hitW[1]) begin
            rdSel = rd1W;
        end else begin
            hitSel = 1'b0;
        end
    end

    // read data registered at setup, so access needs no wait state
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            prdata <= 32'h00000000;
            err_q <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h00000000 : rdSel;
            err_q <= ~hitSel;
        end
    end

    // sticky flags: a new terminal count wins over a clearing write
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            intStat_q <= 2'h0;
            intMask_q <= 2'h0;
        end else begin
            if (wrAcc && paddr == `GCP_OFS_INTMASK) begin
                intMask_q <= pwdata[1:0];
            end
            if (wrAcc && paddr == `GCP_OFS_INTSTAT) begin
                intStat_q <= (intStat_q & ~pwdata[1:0]) | tcW;
            end else begin
                intStat_q <= intStat_q | tcW;
            end
        end
    end

    // =================================================================
    // the two counters
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : ctr
            reg [`GCP_CFG_W-1:0] cfg_q;
            reg [23:0] start_q;
            reg [23:0] durA_q;
            reg [23:0] durB_q;
            reg [23:0] durC_q;
            reg [23:0] durD_q;
            reg [7:0] step_q;
            reg [`GCP_CFG_W-1:0] aCfg_q;
            reg [23:0] aA_q;
            reg [23:0] aB_q;
            reg [23:0] aC_q;
            reg [23:0] aD_q;
            reg [7:0] aStep_q;
            reg [23:0] cnt_q;
            reg armed_q;
            reg dirUp_q;
            reg phase_q;
            reg outLvl_q;
            reg tc_q;
            reg outPin_q;
            reg srcPrev_q;
            reg [31:0] rd;
            wire [5:0] ofs;
            wire sel;
            wire wr;
            wire [5:0] cmd;
            wire [19:0] srcVec;
            wire [19:0] gateVec;
            wire [4:0] srcCode;
            wire [4:0] gateCode;
            wire srcSig;
            wire edgeHit;
            wire gateAct;
            wire isTally;
            wire up;
            wire step;
            wire tcNow;
            wire [23:0] lowDur;
            wire [23:0] highDur;
            wire useAB;

            assign ofs = paddr[5:0];
            assign sel = (paddr[7:6] == i[1:0]) && (ofs <= `GCP_OFS_STAT) && (ofs[1:0] == 2'h0);
            assign hitW[i] = sel;
            assign wr = wrAcc & sel;
            assign cmd = (wr && ofs == `GCP_OFS_CMD) ? pwdata[5:0] : 6'h00;

            // source and gate selection
            assign srcVec = {tcW[1-i], slowTick, fastTick, trigS, pinS};
            assign gateVec = {outW[1-i], acqEndS, acqBeginS, trigS, pinS};
            assign srcCode = aCfg_q[`GCP_SRC];
            assign gateCode = aCfg_q[`GCP_GATE];
            assign srcSig = (srcCode <= `GCP_SEL_LAST) ? srcVec[srcCode] : 1'b0;
            // timebase and companion tc are already one-cycle events
            assign edgeHit = (srcCode >= `GCP_SRC_FAST) ? srcSig :
                             aCfg_q[`GCP_EDGE] ? (~srcSig & srcPrev_q) :
                             (srcSig & ~srcPrev_q);
            assign gateAct = ((gateCode <= `GCP_SEL_LAST) ? gateVec[gateCode] : 1'b0)
                             ^ aCfg_q[`GCP_GSENSE];

            // direction only matters for tallies
            assign isTally = (aCfg_q[`GCP_APP] == `GCP_APP_PLAIN_TALLY) ||
                             (aCfg_q[`GCP_APP] == `GCP_APP_STORED_TALLY);
            assign up = (aCfg_q[`GCP_DIR] == `GCP_DIR_LINE) ?
                        pioS[(i == 0) ? `GCP_PIO_DIR0 : `GCP_PIO_DIR1] : dirUp_q;
            assign step = armed_q & edgeHit & (isTally ? gateAct : 1'b1);

            // fsk picks the duration pair by gate state
            assign useAB = (aCfg_q[`GCP_APP] != `GCP_APP_FSK) | gateAct;
            assign lowDur = useAB ? aA_q : aC_q;
            assign highDur = useAB ? aB_q : aD_q;

            assign tcNow = step & (isTally ? (up ? (cnt_q == `GCP_CNT_MAX) : (cnt_q == 24'h000000))
                                            : (cnt_q <= 24'h000001));

            assign tcW[i] = tc_q;
            assign outW[i] = outPin_q;

            always @* begin
                rd = 32'h00000000;
                case (ofs)
                    `GCP_OFS_CFG: rd = {14'h0000, cfg_q};
                    `GCP_OFS_START: rd = {8'h00, start_q};
                    `GCP_OFS_DURA: rd = {8'h00, durA_q};
                    `GCP_OFS_DURB: rd = {8'h00, durB_q};
                    `GCP_OFS_DURC: rd = {8'h00, durC_q};
                    `GCP_OFS_DURD: rd = {8'h00, durD_q};
                    `GCP_OFS_STEP: rd = {24'h000000, step_q};
                    `GCP_OFS_COUNT: rd = {8'h00, cnt_q};
                    `GCP_OFS_STAT: rd = {28'h0000000, outPin_q, phase_q, up, armed_q};
                    default: rd = 32'h00000000;
                endcase
            end

            // parameter staging; writes land any time but take hold at prepare
            always @(posedge clock or posedge reset) begin
                if (reset) begin
                    cfg_q <= `GCP_CFG_RST;
                    start_q <= 24'h000000;
                    durA_q <= `GCP_MIN_DUR;
                    durB_q <= `GCP_MIN_DUR;
                    durC_q <= `GCP_MIN_DUR;
                    durD_q <= `GCP_MIN_DUR;
                    step_q <= 8'h00;
                end else if (wr) begin
                    case (ofs)
                        `GCP_OFS_CFG: cfg_q <= pwdata[`GCP_CFG_W-1:0];
                        `GCP_OFS_START: start_q <= pwdata[23:0];
                        // durations below two are raised to two
                        `GCP_OFS_DURA: durA_q <= (pwdata[23:0] < `GCP_MIN_DUR) ? `GCP_MIN_DUR : pwdata[23:0];
                        `GCP_OFS_DURB: durB_q <= (pwdata[23:0] < `GCP_MIN_DUR) ? `GCP_MIN_DUR : pwdata[23:0];
                        `GCP_OFS_DURC: durC_q <= (pwdata[23:0] < `GCP_MIN_DUR) ? `GCP_MIN_DUR : pwdata[23:0];
                        `GCP_OFS_DURD: durD_q <= (pwdata[23:0] < `GCP_MIN_DUR) ? `GCP_MIN_DUR : pwdata[23:0];
                        `GCP_OFS_STEP: step_q <= pwdata[7:0];
                        default: step_q <= step_q;
                    endcase
                end
            end

            // counting engine
            always @(posedge clock or posedge reset) begin
                if (reset) begin
                    aCfg_q <= `GCP_CFG_RST;
                    aA_q <= `GCP_MIN_DUR;
                    aB_q <= `GCP_MIN_DUR;
                    aC_q <= `GCP_MIN_DUR;
                    aD_q <= `GCP_MIN_DUR;
                    aStep_q <= 8'h00;
                    cnt_q <= 24'h000000;
                    armed_q <= 1'b0;
                    dirUp_q <= 1'b1;
                    phase_q <= 1'b0;
                    outLvl_q <= 1'b0;
                    tc_q <= 1'b0;
                    outPin_q <= 1'b0;
                    srcPrev_q <= 1'b0;
                end else begin
                    srcPrev_q <= srcSig;
                    tc_q <= tcNow;
                    if (cmd[`GCP_CMD_RESET]) begin
                        armed_q <= 1'b0;
                        phase_q <= 1'b0;
                        outLvl_q <= 1'b0;
                    end else if (cmd[`GCP_CMD_PREPARE] | cmd[`GCP_CMD_PROGRAM]) begin
                        // staged set copied only here, so mid-run edits cannot tear
                        aCfg_q <= cfg_q;
                        aA_q <= durA_q;
                        aB_q <= durB_q;
                        aC_q <= durC_q;
                        aD_q <= durD_q;
                        aStep_q <= step_q;
                        dirUp_q <= (cfg_q[`GCP_DIR] != `GCP_DIR_SW_DOWN);
                        phase_q <= 1'b0;
                        outLvl_q <= 1'b0;
                        cnt_q <= (cfg_q[`GCP_APP] == `GCP_APP_PLAIN_TALLY ||
                                  cfg_q[`GCP_APP] == `GCP_APP_STORED_TALLY) ? start_q : durA_q;
                        armed_q <= cmd[`GCP_CMD_PROGRAM];
                    end else begin
                        if (cmd[`GCP_CMD_ARM]) begin
                            armed_q <= 1'b1;
                        end
                        if (isTally && aCfg_q[`GCP_DIR] != `GCP_DIR_LINE) begin
                            if (cmd[`GCP_CMD_UP]) begin
                                dirUp_q <= 1'b1;
                            end else if (cmd[`GCP_CMD_DOWN]) begin
                                dirUp_q <= 1'b0;
                            end
                        end
                        if (step) begin
                            if (isTally) begin
                                cnt_q <= up ? cnt_q + 24'h000001 : cnt_q - 24'h000001;
                            end else if (tcNow) begin
                                phase_q <= ~phase_q;
                                if (phase_q) begin
                                    cnt_q <= lowDur;
                                    if (useAB) begin
                                        aA_q <= aA_q + {16'h0000, aStep_q};
                                    end
                                end else begin
                                    cnt_q <= highDur;
                                end
                            end else begin
                                cnt_q <= cnt_q - 24'h000001;
                            end
                        end
                        if (tcNow) begin
                            outLvl_q <= ~outLvl_q;
                        end
                    end
                    outPin_q <= (aCfg_q[`GCP_OMODE] ? tc_q : outLvl_q)
                                ^ aCfg_q[`GCP_OSENSE];
                end
            end
        end
    endgenerate

    assign rd0W = ctr[0].rd;
    assign rd1W = ctr[1].rd;
endmodule // gcp_counter_top

`default_nettype wire

// ===== gcp_defines.vh
`ifndef GCP_DEFINES_VH
`define GCP_DEFINES_VH

// =====================================================================
// register offsets, per counter (counter n at n * GCP_CTR_STRIDE)
`define GCP_CTR_STRIDE 8'h40
`define GCP_OFS_CFG 6'h00
`define GCP_OFS_START 6'h04
`define GCP_OFS_DURA 6'h08
`define GCP_OFS_DURB 6'h0C
`define GCP_OFS_DURC 6'h10
`define GCP_OFS_DURD 6'h14
`define GCP_OFS_STEP 6'h18
`define GCP_OFS_CMD 6'h1C
`define GCP_OFS_COUNT 6'h20
`define GCP_OFS_STAT 6'h24
`define GCP_OFS_INTSTAT 8'h80
`define GCP_OFS_INTMASK 8'h84

// =====================================================================
// configuration word fields
`define GCP_CFG_W 18
`define GCP_SRC 4:0
`define GCP_EDGE 5
`define GCP_GATE 10:6
`define GCP_GSENSE 11
`define GCP_APP 13:12
`define GCP_DIR 15:14
`define GCP_OMODE 16
`define GCP_OSENSE 17
`define GCP_CFG_RST 18'h00000

// =====================================================================
// source codes: 0..9 pins, 10..16 triggers, then these
`define GCP_SRC_FAST 5'h11
`define GCP_SRC_SLOW 5'h12
`define GCP_SRC_COMP_TC 5'h13
// gate codes: 0..9 pins, 10..16 triggers, then these
`define GCP_GATE_ACQ_BEGIN 5'h11
`define GCP_GATE_ACQ_END 5'h12
`define GCP_GATE_COMP_OUT 5'h13
`define GCP_SEL_LAST 5'h13

// applications
`define GCP_APP_PLAIN_TALLY 2'h0
`define GCP_APP_STORED_TALLY 2'h1
`define GCP_APP_PULSE_TRAIN 2'h2
`define GCP_APP_FSK 2'h3

// direction control
`define GCP_DIR_SW_UP 2'h0
`define GCP_DIR_SW_DOWN 2'h1
`define GCP_DIR_LINE 2'h2

// command bits
`define GCP_CMD_PREPARE 0
`define GCP_CMD_ARM 1
`define GCP_CMD_PROGRAM 2
`define GCP_CMD_RESET 3
`define GCP_CMD_UP 4
`define GCP_CMD_DOWN 5

// =====================================================================
// timing
`define GCP_CLK_PS 4000
`define GCP_FAST_PS 50000
`define GCP_SLOW_PS 10000000
`define GCP_FAST_DIV (`GCP_FAST_PS / `GCP_CLK_PS)
`define GCP_SLOW_DIV (`GCP_SLOW_PS / `GCP_CLK_PS)

`define GCP_MIN_DUR 24'h000002
`define GCP_CNT_MAX 24'hFFFFFF
`define GCP_PIO_DIR0 6
`define GCP_PIO_DIR1 7

`endif

// ===== gcp_sync.v
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// three-stage synchroniser; output moves once stages two and three agree
module gcp_sync #(
    parameter WIDTH = 1
) (
    input wire clock,
    input wire reset,
    input wire [WIDTH-1:0] async,
    output reg [WIDTH-1:0] synced
);
    reg [WIDTH-1:0] s1_q;
    reg [WIDTH-1:0] s2_q;
    reg [WIDTH-1:0] s3_q;
    integer k;

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            s1_q <= {WIDTH{1'b0}};
            s2_q <= {WIDTH{1'b0}};
            s3_q <= {WIDTH{1'b0}};
            synced <= {WIDTH{1'b0}};
        end else begin
            s1_q <= async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // filters a one-stage glitch at the cost of one more cycle
            for (k = 0; k < WIDTH; k = k + 1) begin
                if (s2_q[k] == s3_q[k]) begin
                    synced[k] <= s3_q[k];
                end
            end
        end
    end
endmodule // gcp_sync

`default_nettype wire

// ===== gcp_counter_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port-level checks of the counter block
module gcp_counter_sva #(
    parameter FAST_DIV = 12,
    parameter SLOW_DIV = 2500
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [1:0] counterOut,
    input wire logic [1:0] terminalCount,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // outputs may only move shortly after a write or a terminal count
    wire evtNow = (psel && penable && pwrite) || (terminalCount != 2'h0);
    wire unmapped = (paddr[1:0] != 2'h0) ||
        (paddr[7] ? (paddr != 8'h80 && paddr != 8'h84) : (paddr[5:0] > 6'h24));
    logic [2:0] age_q;
    wire [2:0] age_d = evtNow ? 3'h0 : (age_q == 3'h7 ? age_q : age_q + 3'h1);
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            age_q <= 3'h7;
        end else begin
            age_q <= age_d;
        end
    end
    sequence s_rd(logic [7:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    sequence s_acc;
        psel && penable;
    endsequence
    a_ready_access: assert property (pready == (psel && penable))
        else $error("pready does not follow the access phase");
    a_err_map: assert property (s_acc |-> pslverr == unmapped)
        else $error("error response does not match the address map");
    a_err_idle: assert property (!(psel && penable) |-> !pslverr)
        else $error("error response outside an access phase");
    a_wr_zero: assert property (psel && !penable && pwrite |=> prdata == 32'h0)
        else $error("read data not zero on a write");
    a_cmd_zero: assert property (s_rd(8'h1C) |=> prdata == 32'h0)
        else $error("command register reads nonzero");
    a_step_width: assert property (s_rd(8'h18) |=> prdata[31:8] == 24'h0)
        else $error("reload step wider than eight bits");
    a_count_width: assert property (s_rd(8'h20) |=> prdata[31:24] == 8'h0)
        else $error("count wider than 24 bits");
    a_tc_pulse: assert property (terminalCount != 2'h0 |=> (terminalCount & $past(terminalCount)) == 2'h0)
        else $error("terminal count longer than one cycle");
    a_out_cause: assert property ($changed(counterOut) |-> evtNow || age_q <= 3'h4)
        else $error("counter output moved without cause");
    a_irq_cause: assert property ($rose(irq) |-> evtNow || age_q <= 3'h3)
        else $error("interrupt rose without cause");
    a_quiet_reset: assert property ($fell(reset) |-> counterOut == 2'h0 && terminalCount == 2'h0 && !irq)
        else $error("outputs not at rest after reset");
endmodule // gcp_counter_sva
bind gcp_counter_top gcp_counter_sva #(.FAST_DIV(FAST_DIV), .SLOW_DIV(SLOW_DIV)) chk (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .counterOut(counterOut), .terminalCount(terminalCount), .irq(irq));
`default_nettype wire

// ===== gcp_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// pins, trigger lines and io lines around the block
module gcp_pins_model (
    input wire logic clock,
    output var logic [9:0] connectorPin,
    output var logic [6:0] triggerLine,
    output var logic acqBegin,
    output var logic acqEnd,
    output var logic [7:0] parallelIoLine
);
    initial begin
        connectorPin = 10'h000;
        triggerLine = 7'h00;
        acqBegin = 1'b0;
        acqEnd = 1'b0;
        parallelIoLine = 8'h00;
    end
    // each level held 13 cycles: the block synchronises over several flops
    task automatic drivePin(input int idx, input logic lvl);
        @(posedge clock);
        connectorPin[idx] <= lvl;
        repeat (12) @(posedge clock);
    endtask
    task automatic pulsePin(input int idx, input int n);
        repeat (n) begin
            drivePin(idx, 1'b1);
            drivePin(idx, 1'b0);
        end
    endtask
    task automatic setLine(input int idx, input logic lvl);
        @(posedge clock);
        parallelIoLine[idx] <= lvl;
        repeat (12) @(posedge clock);
    endtask
endmodule // gcp_pins_model
`default_nettype wire

// ===== gcp_counter_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench for the two-counter block
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin nErrors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module gcp_counter_top_bench;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    wire pready;
    wire [31:0] prdata;
    wire pslverr;
    wire [9:0] pin;
    wire [6:0] trig;
    wire acqB;
    wire acqE;
    wire [7:0] pio;
    wire [1:0] cOut;
    wire [1:0] tc;
    wire irq;
    int nErrors = 0;
    int testsRun = 0;
    int tcCnt0 = 0;
    int outRise0 = 0;
    int n;
    logic prevOut0 = 1'b0;
    logic [31:0] rdv;
    logic errv;
    always #2 clock = ~clock;
    gcp_counter_top #(.FAST_DIV(2), .SLOW_DIV(4)) dut (.clock(clock), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .connectorPin(pin),
        .triggerLine(trig), .acquisitionBeginTrigger(acqB), .acquisitionEndTrigger(acqE),
        .parallelIoLine(pio), .counterOut(cOut), .terminalCount(tc), .irq(irq));
    gcp_pins_model pins (.clock(clock), .connectorPin(pin), .triggerLine(trig),
        .acqBegin(acqB), .acqEnd(acqE), .parallelIoLine(pio));
    always @(posedge clock) begin
        if (tc[0] === 1'b1) tcCnt0++;
        if (cOut[0] === 1'b1 && prevOut0 === 1'b0) outRise0++;
        prevOut0 <= cOut[0];
    end
    task automatic results();
        $display("counts: testsRun=%0d nErrors=%0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            k++;
            if (k > 20) begin
                nErrors++;
                results();
            end
            @(posedge clock);
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdv, e)
    endtask
    // gate is pin 9, held low by the pin model, so sense set means gate active
    function automatic logic [31:0] cfg(input logic [4:0] s, input logic e, input logic gs,
            input logic [1:0] app, input logic [1:0] dir, input logic om, input logic os);
        cfg = {14'h0, os, om, dir, app, gs, 5'h09, e, s};
    endfunction
    task automatic tResetValues();
        rdChk(8'h00, 32'h0);
        rdChk(8'h20, 32'h0);
        `CHK(cOut, 2'h0)
        apb(1'b0, 8'h28, 32'h0);
        `CHK(errv, 1'b1)
        $display("test reset_values done");
    endtask
    task automatic tTally();
        wr(8'h00, cfg(5'd3, 1'b0, 1'b1, 2'h0, 2'h0, 1'b0, 1'b0));
        wr(8'h04, 32'h5);
        wr(8'h1C, 32'h04);
        rdChk(8'h24, 32'h3);
        pins.pulsePin(3, 3);
        rdChk(8'h20, 32'h8);
        wr(8'h1C, 32'h20);
        pins.pulsePin(3, 2);
        rdChk(8'h20, 32'h6);
        wr(8'h1C, 32'h08);
        pins.pulsePin(3, 1);
        rdChk(8'h20, 32'h6);
        wr(8'h00, cfg(5'd3, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0, 1'b0));
        wr(8'h1C, 32'h04);
        pins.pulsePin(3, 1);
        rdChk(8'h20, 32'h5);
        wr(8'h00, cfg(5'd3, 1'b1, 1'b1, 2'h0, 2'h0, 1'b0, 1'b0));
        wr(8'h04, 32'h0);
        wr(8'h1C, 32'h04);
        pins.drivePin(3, 1'b1);
        rdChk(8'h20, 32'h0);
        pins.drivePin(3, 1'b0);
        rdChk(8'h20, 32'h1);
        $display("test tally done");
    endtask
    task automatic tLine();
        wr(8'h00, cfg(5'd3, 1'b0, 1'b1, 2'h0, 2'h2, 1'b0, 1'b0));
        wr(8'h04, 32'hA);
        wr(8'h1C, 32'h04);
        pins.setLine(6, 1'b0);
        pins.pulsePin(3, 2);
        rdChk(8'h20, 32'h8);
        pins.setLine(6, 1'b1);
        pins.pulsePin(3, 1);
        rdChk(8'h20, 32'h9);
        // a software command has no say under line control
        wr(8'h1C, 32'h20);
        pins.pulsePin(3, 1);
        rdChk(8'h20, 32'hA);
        $display("test line_direction done");
    endtask
    task automatic tWrap();
        wr(8'h80, 32'h3);
        wr(8'h84, 32'h0);
        wr(8'h40, cfg(5'd19, 1'b0, 1'b1, 2'h0, 2'h0, 1'b0, 1'b0));
        wr(8'h44, 32'h0);
        wr(8'h5C, 32'h04);
        wr(8'h00, cfg(5'd3, 1'b0, 1'b1, 2'h0, 2'h1, 1'b0, 1'b0));
        wr(8'h04, 32'h0);
        wr(8'h1C, 32'h04);
        n = tcCnt0;
        pins.pulsePin(3, 1);
        rdChk(8'h20, 32'hFFFFFF);
        `CHK(tcCnt0 - n, 1)
        rdChk(8'h60, 32'h1);
        `CHK(irq, 1'b0)
        rdChk(8'h80, 32'h1);
        wr(8'h84, 32'h1);
        `CHK(irq, 1'b1)
        wr(8'h80, 32'h1);
        `CHK(irq, 1'b0)
        $display("test wrap_irq done");
    endtask
    task automatic tGen();
        wr(8'h08, 32'h2);
        wr(8'h0C, 32'h2);
        wr(8'h10, 32'h0);
        wr(8'h18, 32'h1);
        wr(8'h00, cfg(5'd3, 1'b0, 1'b1, 2'h2, 2'h0, 1'b0, 1'b1));
        wr(8'h1C, 32'h04);
        rdChk(8'h10, 32'h2);
        `CHK(cOut[0], 1'b1)
        n = tcCnt0;
        pins.pulsePin(3, 6);
        `CHK(tcCnt0 - n, 3)
        `CHK(cOut[0], 1'b0)
        pins.pulsePin(3, 4);
        `CHK(tcCnt0 - n, 4)
        `CHK(cOut[0], 1'b1)
        wr(8'h08, 32'h2);
        wr(8'h00, cfg(5'd3, 1'b0, 1'b1, 2'h2, 2'h0, 1'b1, 1'b0));
        wr(8'h1C, 32'h04);
        n = outRise0;
        pins.pulsePin(3, 2);
        `CHK(outRise0 - n, 1)
        `CHK(cOut[0], 1'b0)
        $display("test generation done");
    endtask
    initial begin
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        tResetValues();
        tTally();
        tLine();
        tWrap();
        tGen();
        results();
    end
    initial begin
        repeat (100000) @(posedge clock);
        nErrors++;
        results();
    end
endmodule // gcp_counter_top_bench
`default_nettype wire
